/* File: design/admr_bank.sv */
/*
 Mode register bank of a stereo audio converter, reached through the
 4-wire serial control port, plus the decoded mode bundle it drives.
 Assumes the serial pins and zero flags are asynchronous to core_clk_i and
 that the control bit clock is at least a few system clocks per phase.

 // Contract
 // [R1] Separate 8-bit left/right attenuation, 0.5 dB steps plus mute, reset 0 dB.
 // [R2] Attenuation load enable resets disabled, acts only in sample-data mode.
 // [R3] 3-bit input format selector, resets to 24-bit I2S.
 // [R4] 2-bit de-emphasis rate selector, resets disabled.
 // [R5] In stream mode the de-emphasis selector picks FIR filter performance.
 // [R6] De-emphasis enable resets disabled, acts only in sample-data mode.
 // [R7] Soft mute enable resets to mute disabled.
 // [R8] Phase reversal bit, resets normal, honoured in every mode.
 // [R9] Converter operation bit resets enabled, applies in all modes.
 // [R10] Shared pins select data input or zero flag output, reset input.
 // [R11] Bypass stereo select, bypass mode only, resets monaural.
 // [R12] Roll-off select bit, resets sharp.
 // [R13] Infinite-zero mute resets disabled, sample-data and bypass modes.
 // [R14] System reset control bit, resets to normal operation.
 // [R15] One-bit stream mode enable, resets disabled.
 // [R16] Filter bypass bit, resets to internal filter in use.
 // [R17] Mono bit resets stereo; mono channel select resets left.
 // [R18] Oversampling field resets x64; in stream mode sets FIR rate.
 // [R19] Sample zero output resets enabled; stream zero field resets disabled.
 // [R20] Read-only per-channel zero flags, 1 when zero detected.
 // [R21] Read-only 5-bit device identifier register.
 // [R22] Host reaches the bank only through the serial control port.
 // [R23] Access is one 16-bit word: direction, 7-bit index, 8-bit data.
 // [R24] Attenuation writes apply only while load enable is set.
 // [R25] Writes to read-only and reserved bits ignored; reserved reads zero.
*/
`timescale 1ns/1ps
`include "admr_defs.svh"

module admr_bank
   import admr_pkg::*;
(
   input  wire logic       core_clk_i,      // System clock, 100 MHz
   input  wire logic       nrst_i,          // Synchronous reset, active low
   input  wire logic       ce_i,            // Clock enable, freezes state when low
   input  wire logic       ms_n_i,          // Mode control enable, active low
   input  wire logic       mc_i,            // Control bit clock
   input  wire logic       mdi_i,           // Control serial data in
   input  wire logic       left_zero_i,     // Left channel zero detected
   input  wire logic       right_zero_i,    // Right channel zero detected
   output logic            mdo_o,           // Control serial data out
   output logic            mdo_oe_o,        // Drive enable for mdo_o
   output admr_mode_t      mode_o           // Decoded mode bundle
);

   ////////////////////////////////////////////////////////////////////////
   // State

   admr_state_t st;
   admr_state_t next_st;

   logic        ms_fall;
   logic        ms_rise;
   logic        mc_rise;
   logic        mc_fall;
   logic [15:0] word;
   logic [6:0]  hdr_idx;
   logic [7:0]  rd_data;
   logic        normal_mode;

   // Reset words as vectors so that single fields can be selected
   localparam logic [7:0] RST_FMT  = `ADMR_RST_FMT;
   localparam logic [7:0] RST_ZOUT = `ADMR_RST_ZOUT;

   ////////////////////////////////////////////////////////////////////////
   // Read mux, reserved bits zero

   function automatic logic [7:0] read_reg(input logic [6:0] idx,
                                           input admr_state_t s);
      logic [7:0] d;
      d = 8'h00;
      if (idx == `ADMR_IDX_LATT) begin
         d = s.left_atten_level;
      end else if (idx == `ADMR_IDX_RATT) begin
         d = s.right_atten_level;
      end else if (idx == `ADMR_IDX_FMT) begin
         d = s.format_and_mute_ctrl;
      end else if (idx == `ADMR_IDX_OUT) begin
         d = s.output_and_filter_ctrl;
      end else if (idx == `ADMR_IDX_IFM) begin
         d = s.interface_mode_ctrl & `ADMR_MASK_IFM;                  // R25
      end else if (idx == `ADMR_IDX_ZOUT) begin
         d = s.zero_output_ctrl & `ADMR_MASK_ZOUT;                    // R25
      end else if (idx == `ADMR_IDX_ZSTAT) begin
         d = {6'h00, s.zf_s2[1], s.zf_s2[0]};                         // R20
      end else if (idx == `ADMR_IDX_DEVID) begin
         d = {3'h0, `ADMR_DEV_ID};                                    // R21
      end
      return d;
   endfunction : read_reg

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st = st;

      // Two-stage synchronisers; only the second stage feeds logic
      next_st.ms_s1  = ms_n_i;
      next_st.ms_s2  = st.ms_s1;
      next_st.ms_d   = st.ms_s2;
      next_st.mc_s1  = mc_i;
      next_st.mc_s2  = st.mc_s1;
      next_st.mc_d   = st.mc_s2;
      next_st.mdi_s1 = mdi_i;
      next_st.mdi_s2 = st.mdi_s1;
      next_st.zf_s1  = {right_zero_i, left_zero_i};
      next_st.zf_s2  = st.zf_s1;

      ms_fall = st.ms_d & ~st.ms_s2;
      ms_rise = ~st.ms_d & st.ms_s2;
      mc_rise = ~st.mc_d & st.mc_s2 & ~st.ms_s2;
      mc_fall = st.mc_d & ~st.mc_s2 & ~st.ms_s2;

      word        = {st.in_sr[14:0], st.mdi_s2};
      hdr_idx     = word[6:0];
      rd_data     = read_reg(hdr_idx, st);
      normal_mode = ~st.interface_mode_ctrl[`ADMR_STREAM_BIT]
                    & ~st.interface_mode_ctrl[`ADMR_BYPASS_BIT];

      // Frame control: enable low starts a word, high ends it
      if (ms_fall) begin                                              // R22
         next_st.busy = 1'b1;
         next_st.rd   = 1'b0;
         next_st.cnt  = 5'h00;
      end else if (ms_rise) begin
         next_st.busy   = 1'b0;
         next_st.mdo_oe = 1'b0;
         next_st.mdo    = 1'b0;
      end else if (st.busy && mc_rise && st.cnt < `ADMR_WORD_BITS) begin
         next_st.in_sr = word;                                        // R23
         next_st.cnt   = st.cnt + 5'h01;
         if (st.cnt == `ADMR_HEAD_BITS - 5'h01) begin
            next_st.rd = word[7];                                     // R23
            if (word[7]) begin
               next_st.out_sr = rd_data;
               next_st.mdo    = rd_data[7];
               next_st.mdo_oe = 1'b1;
            end
         end
         if (st.cnt == `ADMR_WORD_BITS - 5'h01 && !st.rd) begin
            // Write commits on the sixteenth bit
            if (word[`ADMR_IDX_MSB:`ADMR_IDX_LSB] == `ADMR_IDX_LATT) begin
               next_st.left_atten_level = word[7:0];                  // R1
               if (st.format_and_mute_ctrl[`ADMR_ATTEN_LOAD_ENABLE_BIT] && normal_mode) begin
                  next_st.mode.left_atten_level = word[7:0];          // R24
               end
            end else if (word[`ADMR_IDX_MSB:`ADMR_IDX_LSB] == `ADMR_IDX_RATT) begin
               next_st.right_atten_level = word[7:0];                 // R1
               if (st.format_and_mute_ctrl[`ADMR_ATTEN_LOAD_ENABLE_BIT] && normal_mode) begin
                  next_st.mode.right_atten_level = word[7:0];         // R24
               end
            end else if (word[`ADMR_IDX_MSB:`ADMR_IDX_LSB] == `ADMR_IDX_FMT) begin
               next_st.format_and_mute_ctrl = word[7:0];              // R3
            end else if (word[`ADMR_IDX_MSB:`ADMR_IDX_LSB] == `ADMR_IDX_OUT) begin
               next_st.output_and_filter_ctrl = word[7:0];            // R8
            end else if (word[`ADMR_IDX_MSB:`ADMR_IDX_LSB] == `ADMR_IDX_IFM) begin
               next_st.interface_mode_ctrl = word[7:0] & `ADMR_MASK_IFM;   // R25
            end else if (word[`ADMR_IDX_MSB:`ADMR_IDX_LSB] == `ADMR_IDX_ZOUT) begin
               next_st.zero_output_ctrl = word[7:0] & `ADMR_MASK_ZOUT;     // R25
            end
         end
      end else if (st.busy && st.rd && mc_fall
                   && st.cnt > `ADMR_HEAD_BITS && st.cnt < `ADMR_WORD_BITS) begin
         // Readback shifts out on falling bit-clock edges
         next_st.out_sr = {st.out_sr[6:0], 1'b0};
         next_st.mdo    = st.out_sr[6];
      end

      // Decoded mode bundle from the updated registers
      next_st.mode.atten_load_enable =
         next_st.format_and_mute_ctrl[`ADMR_ATTEN_LOAD_ENABLE_BIT];                // R2
      next_st.mode.input_format_select =
         next_st.format_and_mute_ctrl[`ADMR_FMT_MSB:`ADMR_FMT_LSB];   // R3
      if (next_st.interface_mode_ctrl[`ADMR_STREAM_BIT]) begin
         next_st.mode.deemph_rate_select = 2'h0;
         next_st.mode.fir_perf_select =
            next_st.format_and_mute_ctrl[`ADMR_DMF_MSB:`ADMR_DMF_LSB];     // R5
         next_st.mode.oversample_rate_select = 2'h0;
         next_st.mode.fir_rate_select =
            next_st.interface_mode_ctrl[`ADMR_OS_MSB:`ADMR_OS_LSB];        // R18
      end else begin
         next_st.mode.deemph_rate_select =
            next_st.format_and_mute_ctrl[`ADMR_DMF_MSB:`ADMR_DMF_LSB];     // R4
         next_st.mode.fir_perf_select = 2'h0;
         next_st.mode.oversample_rate_select =
            next_st.interface_mode_ctrl[`ADMR_OS_MSB:`ADMR_OS_LSB];        // R18
         next_st.mode.fir_rate_select = 2'h0;
      end
      next_st.mode.deemph_enable =
         next_st.format_and_mute_ctrl[`ADMR_DME_BIT]
         & ~next_st.interface_mode_ctrl[`ADMR_STREAM_BIT]
         & ~next_st.interface_mode_ctrl[`ADMR_BYPASS_BIT];            // R6
      next_st.mode.soft_mute =
         next_st.format_and_mute_ctrl[`ADMR_MUTE_BIT];                // R7
      next_st.mode.phase_reverse =
         next_st.output_and_filter_ctrl[`ADMR_REV_BIT];               // R8
      next_st.mode.atten_speed_select =
         next_st.output_and_filter_ctrl[`ADMR_ATS_MSB:`ADMR_ATS_LSB];
      next_st.mode.converter_operation =
         next_st.output_and_filter_ctrl[`ADMR_OPE_BIT];               // R9
      next_st.mode.zero_flag_pin_select =
         next_st.output_and_filter_ctrl[`ADMR_ZOE_BIT];               // R10
      next_st.mode.bypass_stereo_select =
         next_st.output_and_filter_ctrl[`ADMR_BYPASS_STEREO_SELECT_BIT]
         & next_st.interface_mode_ctrl[`ADMR_BYPASS_BIT];             // R11
      next_st.mode.rolloff_select =
         next_st.output_and_filter_ctrl[`ADMR_FLT_BIT];               // R12
      next_st.mode.infinite_zero_mute =
         next_st.output_and_filter_ctrl[`ADMR_INFINITE_ZERO_MUTE_BIT]
         & ~next_st.interface_mode_ctrl[`ADMR_STREAM_BIT];            // R13
      next_st.mode.system_reset_ctrl =
         next_st.interface_mode_ctrl[`ADMR_SYSTEM_RESET_CTRL_BIT];                 // R14
      next_st.mode.one_bit_stream_enable =
         next_st.interface_mode_ctrl[`ADMR_STREAM_BIT];               // R15
      next_st.mode.filter_bypass =
         next_st.interface_mode_ctrl[`ADMR_BYPASS_BIT];               // R16
      next_st.mode.mono_mode =
         next_st.interface_mode_ctrl[`ADMR_MONO_BIT];                 // R17
      next_st.mode.mono_channel_select =
         next_st.interface_mode_ctrl[`ADMR_MONO_CHANNEL_SELECT_BIT];                 // R17
      next_st.mode.sample_zero_output_enable =
         next_st.zero_output_ctrl[`ADMR_SAMPLE_ZERO_OUTPUT_ENABLE_BIT];                    // R19
      next_st.mode.stream_zero_output_enable =
         next_st.zero_output_ctrl[`ADMR_DZ_MSB:`ADMR_DZ_LSB];         // R19
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         st                        <= '0;
         st.ms_s1                  <= 1'b1;
         st.ms_s2                  <= 1'b1;
         st.ms_d                   <= 1'b1;
         st.left_atten_level       <= `ADMR_RST_ATT;                  // R1
         st.right_atten_level      <= `ADMR_RST_ATT;                  // R1
         st.format_and_mute_ctrl   <= `ADMR_RST_FMT;                  // R3
         st.output_and_filter_ctrl <= `ADMR_RST_OUT;                  // R9
         st.interface_mode_ctrl    <= `ADMR_RST_IFM;                  // R14
         st.zero_output_ctrl       <= `ADMR_RST_ZOUT;                 // R19
         st.mode.left_atten_level  <= `ADMR_RST_ATT;
         st.mode.right_atten_level <= `ADMR_RST_ATT;
         st.mode.input_format_select <= RST_FMT[`ADMR_FMT_MSB:`ADMR_FMT_LSB];
         st.mode.sample_zero_output_enable <= RST_ZOUT[`ADMR_SAMPLE_ZERO_OUTPUT_ENABLE_BIT];
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign mdo_o    = st.mdo;
   assign mdo_oe_o = st.mdo_oe;
   assign mode_o   = st.mode;

endmodule : admr_bank

/* File: design/admr_defs.svh */
/*
 Register indices, field positions, reset values and frame counts of the
 audio converter mode register bank.
 Assumes it is included by the package, the bank module and the bench.
*/
`ifndef ADMR_DEFS_SVH
`define ADMR_DEFS_SVH

// Register indices carried in bits 14..8 of a control word
`define ADMR_IDX_LATT      7'h10
`define ADMR_IDX_RATT      7'h11
`define ADMR_IDX_FMT       7'h12
`define ADMR_IDX_OUT       7'h13
`define ADMR_IDX_IFM       7'h14
`define ADMR_IDX_ZOUT      7'h15
`define ADMR_IDX_ZSTAT     7'h16
`define ADMR_IDX_DEVID     7'h17

// Control word layout
`define ADMR_WORD_BITS     5'h10
`define ADMR_HEAD_BITS     5'h08
`define ADMR_RW_BIT        15
`define ADMR_IDX_MSB       14
`define ADMR_IDX_LSB       8

// format_and_mute_ctrl fields
`define ADMR_ATTEN_LOAD_ENABLE_BIT      7
`define ADMR_FMT_MSB       6
`define ADMR_FMT_LSB       4
`define ADMR_DMF_MSB       3
`define ADMR_DMF_LSB       2
`define ADMR_DME_BIT       1
`define ADMR_MUTE_BIT      0

// output_and_filter_ctrl fields
`define ADMR_REV_BIT       7
`define ADMR_ATS_MSB       6
`define ADMR_ATS_LSB       5
`define ADMR_OPE_BIT       4
`define ADMR_ZOE_BIT       3
`define ADMR_BYPASS_STEREO_SELECT_BIT      2
`define ADMR_FLT_BIT       1
`define ADMR_INFINITE_ZERO_MUTE_BIT      0

// interface_mode_ctrl fields
`define ADMR_SYSTEM_RESET_CTRL_BIT      6
`define ADMR_STREAM_BIT    5
`define ADMR_BYPASS_BIT    4
`define ADMR_MONO_BIT      3
`define ADMR_MONO_CHANNEL_SELECT_BIT      2
`define ADMR_OS_MSB        1
`define ADMR_OS_LSB        0

// zero_output_ctrl fields
`define ADMR_DZ_MSB        2
`define ADMR_DZ_LSB        1
`define ADMR_SAMPLE_ZERO_OUTPUT_ENABLE_BIT      0

// Reset values
`define ADMR_RST_ATT       8'hFF
`define ADMR_RST_FMT       8'h50
`define ADMR_RST_OUT       8'h00
`define ADMR_RST_IFM       8'h00
`define ADMR_RST_ZOUT      8'h01

// Writable bit masks
`define ADMR_MASK_IFM      8'h7F
`define ADMR_MASK_ZOUT     8'h07

// Device identifier, value arbitrary
`define ADMR_DEV_ID        5'h0A

`endif

/* File: design/admr_pkg.sv */
/*
 Types of the audio converter mode register bank: the decoded mode bundle
 and the whole state of the bank.
 Assumes admr_defs.svh is on the include path.
*/
`include "admr_defs.svh"

package admr_pkg;

   typedef struct packed {
      logic [7:0] left_atten_level;          // Applied left attenuation
      logic [7:0] right_atten_level;         // Applied right attenuation
      logic       atten_load_enable;
      logic [2:0] input_format_select;
      logic [1:0] deemph_rate_select;        // Zero while in stream mode
      logic [1:0] fir_perf_select;           // Zero outside stream mode
      logic       deemph_enable;             // Gated to sample-data mode
      logic       soft_mute;
      logic       phase_reverse;
      logic [1:0] atten_speed_select;
      logic       converter_operation;       // 0 = enabled
      logic       zero_flag_pin_select;      // 0 = data input
      logic       bypass_stereo_select;      // Gated to bypass mode
      logic       rolloff_select;            // 0 = sharp
      logic       infinite_zero_mute;        // Gated off in stream mode
      logic       system_reset_ctrl;         // 1 = reset operation
      logic       one_bit_stream_enable;
      logic       filter_bypass;
      logic       mono_mode;
      logic       mono_channel_select;       // 0 = left
      logic [1:0] oversample_rate_select;    // Zero while in stream mode
      logic [1:0] fir_rate_select;           // Zero outside stream mode
      logic       sample_zero_output_enable;
      logic [1:0] stream_zero_output_enable;
   } admr_mode_t;

   typedef struct packed {
      logic       ms_s1;
      logic       ms_s2;
      logic       ms_d;
      logic       mc_s1;
      logic       mc_s2;
      logic       mc_d;
      logic       mdi_s1;
      logic       mdi_s2;
      logic [1:0] zf_s1;
      logic [1:0] zf_s2;
      logic       busy;
      logic       rd;
      logic [4:0] cnt;
      logic [15:0] in_sr;
      logic [7:0] out_sr;
      logic [7:0] left_atten_level;
      logic [7:0] right_atten_level;
      logic [7:0] format_and_mute_ctrl;
      logic [7:0] output_and_filter_ctrl;
      logic [7:0] interface_mode_ctrl;
      logic [7:0] zero_output_ctrl;
      logic       mdo;
      logic       mdo_oe;
      admr_mode_t mode;
   } admr_state_t;

endpackage : admr_pkg

/* File: tb/admr_host.sv */
/*
 Host controller model for the 4-wire serial control port.
 Assumes one caller at a time and the core clock as its time base.
*/
`timescale 1ns/1ps
module admr_host (
   input  wire logic core_clk_i,  // System clock
   input  wire logic mdo_i,       // Readback data from the bank
   output logic      ms_n_o,      // Frame enable, active low
   output logic      mc_o,        // Control bit clock
   output logic      mdi_o        // Control serial data
);
   localparam int PH = 5;  // Core clocks per bit clock phase
   initial begin
      ms_n_o = 1'b1;
      mc_o   = 1'b0;
      mdi_o  = 1'b0;
   end
   // Sends the top nbits of word; a short count aborts the frame
   task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rdat);
      rdat = 8'h00;
      @(posedge core_clk_i);
      ms_n_o <= 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         mdi_o <= word[i];
         repeat (PH) @(posedge core_clk_i);
         mc_o <= 1'b1;
         repeat (PH) @(posedge core_clk_i);
         if (i <= 7)
            rdat[i] = mdo_i;
         mc_o <= 1'b0;
      end
      repeat (PH) @(posedge core_clk_i);
      ms_n_o <= 1'b1;
      mdi_o  <= ~mdi_o;
      repeat (PH) @(posedge core_clk_i);
   endtask : xfer
endmodule : admr_host

/* File: tb/admr_bank_sva.sv */
/*
 Checker for the mode register bank, bound to its ports.
 Assumes the serial port contract of the bank.
*/
`timescale 1ns/1ps
module admr_bank_chk
   import admr_pkg::*;
(
   input wire logic       core_clk_i,  // System clock
   input wire logic       nrst_i,      // Synchronous reset, active low
   input wire logic       ce_i,        // Clock enable
   input wire logic       ms_n_i,      // Frame enable, active low
   input wire logic       mdo_o,       // Readback data
   input wire logic       mdo_oe_o,    // Readback drive enable
   input wire admr_mode_t mode_o       // Decoded modes
);
   default clocking cb @(posedge core_clk_i); endclocking
   chk_reset_atten: assert property (!nrst_i |=> mode_o.left_atten_level == 8'hFF
      && mode_o.right_atten_level == 8'hFF) else $error("attenuation reset wrong");
   chk_reset_format: assert property (!nrst_i |=> mode_o.input_format_select == 3'h5
      && mode_o.deemph_rate_select == 2'h0 && !mode_o.deemph_enable && !mode_o.soft_mute
      && !mode_o.atten_load_enable) else $error("format reset wrong");
   chk_reset_ctrl: assert property (!nrst_i |=> {mode_o.phase_reverse,
      mode_o.converter_operation, mode_o.zero_flag_pin_select, mode_o.rolloff_select,
      mode_o.system_reset_ctrl, mode_o.one_bit_stream_enable, mode_o.filter_bypass,
      mode_o.mono_mode, mode_o.mono_channel_select, mode_o.oversample_rate_select} == 11'h0)
      else $error("control reset wrong");
   chk_reset_zero: assert property (!nrst_i |=> mode_o.sample_zero_output_enable
      && mode_o.stream_zero_output_enable == 2'h0) else $error("zero output reset wrong");
   chk_reset_port: assert property (!nrst_i |=> !mdo_oe_o && !mdo_o)
      else $error("readback port not idle after reset");
   chk_atten_hold: assert property (disable iff (!nrst_i) $past(nrst_i)
      && ($changed(mode_o.left_atten_level) || $changed(mode_o.right_atten_level))
      |-> $past(mode_o.atten_load_enable)) else $error("attenuation applied without load");
   chk_stream_remap: assert property (disable iff (!nrst_i) mode_o.one_bit_stream_enable
      |-> mode_o.deemph_rate_select == 2'h0 && mode_o.oversample_rate_select == 2'h0
      && !mode_o.deemph_enable && !mode_o.infinite_zero_mute) else $error("stream remap wrong");
   chk_normal_remap: assert property (disable iff (!nrst_i) !mode_o.one_bit_stream_enable
      |-> mode_o.fir_perf_select == 2'h0 && mode_o.fir_rate_select == 2'h0)
      else $error("filter fields set outside stream mode");
   chk_bypass_gate: assert property (disable iff (!nrst_i) mode_o.bypass_stereo_select
      |-> mode_o.filter_bypass) else $error("bypass stereo outside bypass mode");
   chk_oe_idle: assert property (disable iff (!nrst_i) (ms_n_i && ce_i)[*6]
      |-> !mdo_oe_o) else $error("readback driven outside a frame");
   chk_oe_quiet: assert property (disable iff (!nrst_i) !mdo_oe_o |-> !mdo_o)
      else $error("readback data not low while released");
   chk_idle_stable: assert property (disable iff (!nrst_i) ms_n_i[*6] |=> $stable(mode_o))
      else $error("modes changed outside a frame");
   cover property (mode_o.one_bit_stream_enable);
   cover property ($rose(mdo_oe_o));
   cover property (nrst_i && $changed(mode_o.left_atten_level));
endmodule : admr_bank_chk

bind admr_bank admr_bank_chk chk_i (
   .core_clk_i (core_clk_i), .nrst_i (nrst_i), .ce_i (ce_i), .ms_n_i (ms_n_i),
   .mdo_o (mdo_o), .mdo_oe_o (mdo_oe_o), .mode_o (mode_o));

/* File: tb/tb_audio_dac_mode_registers.sv */
/*
 Self-checking bench for the mode register bank.
 Assumes the host model frames every register access.
*/
`timescale 1ns/1ps
`include "admr_defs.svh"
module tb_audio_dac_mode_registers;
   logic                 core_clk;
   logic                 nrst;
   logic                 ce;
   logic                 lz;
   logic                 rz;
   wire logic            ms_n;
   wire logic            mc;
   wire logic            mdi;
   wire logic            mdo;
   wire logic            mdo_oe;
   admr_pkg::admr_mode_t md;
   int                   fail_count = 0;
   int                   checks_done = 0;

   admr_bank dut (
      .core_clk_i (core_clk), .nrst_i (nrst), .ce_i (ce), .ms_n_i (ms_n),
      .mc_i (mc), .mdi_i (mdi), .left_zero_i (lz), .right_zero_i (rz),
      .mdo_o (mdo), .mdo_oe_o (mdo_oe), .mode_o (md));
   admr_host host (
      .core_clk_i (core_clk), .mdo_i (mdo), .ms_n_o (ms_n), .mc_o (mc), .mdi_o (mdi));

   always #5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check_val
   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      logic [7:0] r;
      host.xfer({1'b0, idx, d}, 16, r);
   endtask : wr
   task automatic rcheck(input string name, input logic [6:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      host.xfer({1'b1, idx, 8'h00}, 16, r);
      check_val(name, exp, r);
   endtask : rcheck
   task automatic finish_test();
      if (fail_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults();
      rcheck("left atten", 7'h10, 8'hFF);
      rcheck("right atten", 7'h11, 8'hFF);
      rcheck("format reg", 7'h12, 8'h50);
      rcheck("output reg", 7'h13, 8'h00);
      rcheck("mode reg", 7'h14, 8'h00);
      rcheck("zero out reg", 7'h15, 8'h01);
      rcheck("zero flags", 7'h16, 8'h01);
      rcheck("device id", 7'h17, {3'h0, `ADMR_DEV_ID});
      rcheck("unmapped", 7'h20, 8'h00);
   endtask : t_defaults
   task automatic t_fields();
      wr(7'h12, 8'h3B);
      wr(7'h13, 8'hA5);
      rcheck("output rw", 7'h13, 8'hA5);
      check_val("mute", 8'h01, 8'(md.soft_mute));
      check_val("deemph on", 8'h01, 8'(md.deemph_enable));
      check_val("inf zero", 8'h01, 8'(md.infinite_zero_mute));
      check_val("out bits", 8'h28, 8'({md.phase_reverse, md.atten_speed_select,
                md.converter_operation, md.zero_flag_pin_select, md.rolloff_select}));
      wr(7'h14, 8'hFF);
      rcheck("mode rsv", 7'h14, 8'h7F);
      check_val("fir perf", 8'h02, 8'(md.fir_perf_select));
      check_val("fir rate", 8'h03, 8'(md.fir_rate_select));
      check_val("gated", 8'h01, 8'({md.deemph_enable, md.infinite_zero_mute,
                md.bypass_stereo_select}));
      check_val("mode bits", 8'h1F, 8'({md.system_reset_ctrl, md.one_bit_stream_enable,
                md.filter_bypass, md.mono_mode, md.mono_channel_select}));
      wr(7'h15, 8'hFF);
      rcheck("zero rsv", 7'h15, 8'h07);
      check_val("zero out", 8'h07, 8'({md.stream_zero_output_enable,
                md.sample_zero_output_enable}));
      wr(7'h16, 8'hFF);
      wr(7'h17, 8'h00);
      rcheck("flags ro", 7'h16, 8'h01);
      rcheck("id ro", 7'h17, {3'h0, `ADMR_DEV_ID});
      for (int k = 0; k < 6; k++) begin
         wr(7'h14, 8'(k % 3));
         wr(7'h12, 8'((k << 4) | ((k % 4) << 2)));
         check_val("format", 8'(k), 8'(md.input_format_select));
         check_val("deemph sel", 8'(k % 4), 8'(md.deemph_rate_select));
         check_val("os sel", 8'(k % 3), 8'(md.oversample_rate_select));
      end
   endtask : t_fields
   task automatic t_atten();
      wr(7'h10, 8'h80);
      check_val("hold left", 8'hFF, md.left_atten_level);
      wr(7'h12, 8'hD0);
      check_val("no retro", 8'hFF, md.left_atten_level);
      check_val("load bit", 8'h01, 8'(md.atten_load_enable));
      wr(7'h10, 8'h0F);
      wr(7'h11, 8'h0E);
      check_val("left applied", 8'h0F, md.left_atten_level);
      check_val("right applied", 8'h0E, md.right_atten_level);
      wr(7'h12, 8'h50);
      wr(7'h10, 8'h33);
      rcheck("left rb", 7'h10, 8'h33);
      check_val("left kept", 8'h0F, md.left_atten_level);
   endtask : t_atten
   task automatic t_abort_reset();
      logic [7:0] r;
      host.xfer({1'b0, 7'h13, 8'h00}, 12, r);
      rcheck("aborted", 7'h13, 8'hA5);
      lz <= 1'b0;
      rz <= 1'b1;
      rcheck("right flag", 7'h16, 8'h02);
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      rcheck("reset out", 7'h13, 8'h00);
      check_val("reset left", 8'hFF, md.left_atten_level);
      wr(7'h13, 8'h5A);
      check_val("out bits b", 8'h17, 8'({md.phase_reverse, md.atten_speed_select,
                md.converter_operation, md.zero_flag_pin_select, md.rolloff_select}));
      check_val("zero pin", 8'h01, 8'(md.zero_flag_pin_select));
      ce <= 1'b0;
      wr(7'h13, 8'h00);
      ce <= 1'b1;
      repeat (4) @(posedge core_clk);
      rcheck("frozen", 7'h13, 8'h5A);
   endtask : t_abort_reset
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      nrst = 1'b0;
      ce = 1'b1;
      lz = 1'b1;
      rz = 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_defaults();
      t_fields();
      t_atten();
      t_abort_reset();
      finish_test();
   end
   initial begin
      #500us;
      fail_count++;
      finish_test();
   end
endmodule : tb_audio_dac_mode_registers
